// *** design/ofc_pkg.sv ***
// Shared constants, types and checks for the output fault, clear and packet check logic
package ofc_pkg;

    // APB register byte offsets
    localparam logic [7:0] OFC_CFG_OFS = 8'h00;
    localparam logic [7:0] OFC_STATUS_OFS = 8'h04;
    localparam logic [7:0] OFC_MODE_OFS = 8'h08;

    // Fields of the 16-bit serial input word
    localparam int OFC_ADDR_LSB = 13;
    localparam int OFC_RW_BIT = 12;
    localparam int OFC_RANGE_LSB = 7;
    localparam int OFC_CLEAR_LEVEL_SELECT_BIT = 6;
    localparam int OFC_OUTEN_BIT = 5;
    localparam int OFC_RSET_BIT = 4;
    localparam int OFC_SWCLR_BIT = 3;
    localparam int OFC_RESET_BIT = 2;
    localparam logic [15:0] OFC_CFG_RESET = 16'h0000;

    // Status bit positions
    localparam int OFC_ST_VOLTAGE_OUTPUT_PIN = 0;
    localparam int OFC_ST_CURRENT_LOOP_OUTPUT = 1;
    localparam int OFC_ST_TEMP = 2;
    localparam int OFC_ST_PEC = 3;

    // Frame lengths, check polynomial and strap sampling cycles
    localparam logic [4:0] OFC_PLAIN_BITS = 5'h10;
    localparam logic [4:0] OFC_CHECKED_BITS = 5'h18;
    localparam logic [7:0] OFC_CRC_POLY = 8'h07;
    localparam logic [1:0] OFC_STRAP_CYCLES = 2'h3;

    typedef enum logic [1:0] {
        OFC_CLR_ZERO_V,
        OFC_CLR_NEG_FULL,
        OFC_CLR_MID,
        OFC_CLR_LOW_END
    } ofc_clr_e;

    typedef struct packed {
        logic [3:0] range_code;
        logic current_mode;
        logic bipolar;
        logic overrange;
        logic rset_internal;
        logic output_enable;
    } ofc_cfg_s;

    typedef struct packed {
        logic frame_ok;
        logic pec_fail;
        logic [15:0] data;
    } ofc_frame_s;

    // CRC-8, MSB first, zero start
    function automatic logic [7:0] ofc_crc8(input logic [15:0] data);
        logic [7:0] crc;
        crc = 8'h00;
        for (int i = 15; i >= 0; i--) begin
            if (crc[7] ^ data[i]) begin
                crc = {crc[6:0], 1'b0} ^ OFC_CRC_POLY;
            end else begin
                crc = {crc[6:0], 1'b0};
            end
        end
        return crc;
    endfunction

    // Range code to output kind
    function automatic ofc_cfg_s ofc_decode(input logic [3:0] code, input logic rset, input logic outen);
        ofc_cfg_s c;
        c.range_code = code;
        c.current_mode = code[3];
        c.bipolar = code[3] ? (code == 4'hB || code == 4'hC) : code[1];
        c.overrange = code[3] ? (code >= 4'hD) : code[2];
        c.rset_internal = rset;
        c.output_enable = outen;
        return c;
    endfunction

endpackage

// *** design/ofc_serial_rx.sv ***
// Three-wire serial frame receiver with CRC-8 packet check
`timescale 1ns/100ps
module ofc_serial_rx import ofc_pkg::*; (
    input wire logic sys_clk, // System clock
    input wire logic reset_n, // Async reset
    input wire logic sclk, // Link clock pin
    input wire logic sync_n, // Frame sync pin
    input wire logic sdin, // Serial data pin
    output ofc_frame_s frame // Frame result, one-cycle flags
);

    logic [1:0] sclk_s_q, sync_s_q, sdin_s_q;
    logic sclk_d1_q, sync_d1_q;
    logic [23:0] shift_q;
    logic [4:0] count_q;
    logic sclk_fall, sync_fall, sync_rise;

    ////////////////////////////////////////////////////////////////
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            sclk_s_q <= 2'h0;
            sync_s_q <= 2'h3;
            sdin_s_q <= 2'h0;
            sclk_d1_q <= 1'b0;
            sync_d1_q <= 1'b1;
        end else begin
            sclk_s_q <= {sclk_s_q[0], sclk};
            sync_s_q <= {sync_s_q[0], sync_n};
            sdin_s_q <= {sdin_s_q[0], sdin};
            sclk_d1_q <= sclk_s_q[1];
            sync_d1_q <= sync_s_q[1];
        end
    end

    assign sclk_fall = sclk_d1_q && !sclk_s_q[1];
    assign sync_fall = sync_d1_q && !sync_s_q[1];
    assign sync_rise = !sync_d1_q && sync_s_q[1];

    ////////////////////////////////////////////////////////////////
    // falling edge sampling
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            shift_q <= 24'h000000;
            count_q <= 5'h00;
        end else if (sync_fall) begin
            count_q <= 5'h00;
        end else if (sclk_fall && !sync_s_q[1]) begin
            shift_q <= {shift_q[22:0], sdin_s_q[1]};
            // Saturate so an overlong frame is never taken
            if (count_q != 5'h1F) begin
                count_q <= count_q + 5'h01;
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            frame <= '0;
        end else begin
            frame.frame_ok <= 1'b0;
            frame.pec_fail <= 1'b0;
            if (sync_rise) begin
                if (count_q == OFC_PLAIN_BITS) begin
                    frame.frame_ok <= 1'b1;
                    frame.data <= shift_q[15:0];
                end else if (count_q == OFC_CHECKED_BITS) begin
                    frame.data <= shift_q[23:8];
                    if (ofc_crc8(shift_q[23:8]) == shift_q[7:0]) begin
                        frame.frame_ok <= 1'b1;
                    end else begin
                        frame.pec_fail <= 1'b1;
                    end
                end
            end
        end
    end

    crc_outcome_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        sync_rise && count_q == OFC_CHECKED_BITS |=>
        (frame.frame_ok == (ofc_crc8($past(shift_q[23:8])) == $past(shift_q[7:0]))) && (frame.frame_ok != frame.pec_fail))
        else $error("Packet check outcome wrong");

endmodule // ofc_serial_rx

// *** design/ofc_top.sv ***
// Fault alert, clear control and configured range logic with APB access
`timescale 1ns/100ps

module ofc_top import ofc_pkg::*; (
    input wire logic sys_clk, // 20 MHz clock
    input wire logic reset_n, // Async reset, active low
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB direction
    input wire logic [7:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error
    input wire logic sclk, // Serial link clock pin
    input wire logic sync_n, // Serial frame sync pin
    input wire logic sdin, // Serial data pin
    input wire logic [2:0] device_addr, // Address strap pins
    input wire logic hardware_mode_pin, // Mode strap pin
    input wire logic [3:0] range_code_pin, // Range pins, hardware mode
    input wire logic rset_pin, // Sense resistor pin, hardware mode
    input wire logic clear_pin, // Async clear, active high
    input wire logic clear_level_select, // Clear level select pin
    input wire logic headroom_low, // Current stage headroom flag
    input wire logic voltage_short, // Voltage output short flag
    input wire logic over_temp, // Overtemperature flag
    output logic fault_alert_n_o, // Shared alert level
    output logic fault_alert_n_oe, // Shared alert drive enable
    output logic loop_open_alert_n_o, // Current alert level
    output logic loop_open_alert_n_oe, // Current alert drive enable
    output logic voltage_short_alert_n_o, // Voltage alert level
    output logic voltage_short_alert_n_oe, // Voltage alert drive enable
    output logic temp_alert_n_o, // Temperature alert level
    output logic temp_alert_n_oe, // Temperature alert drive enable
    output ofc_cfg_s cfg, // Active range configuration
    output logic clear_active, // Output forced to clear value
    output ofc_clr_e clear_target // Clear value to apply
);

    ofc_frame_s frame;
    logic [1:0] hw_s_q, head_s_q, vsh_s_q, temp_s_q, clear_level_select_s_q, rset_s_q;
    logic [1:0] strap_cnt_q;
    logic [3:0] status_q;
    logic [3:0] rng_s1_q, rng_s2_q;
    logic [15:0] cfg_q;
    logic hw_mode_q;
    logic clear_level_select_eff;
    logic setup, access, mapped, status_rd;
    logic frame_write;
    ofc_cfg_s cfg_d;

    ofc_serial_rx u_rx (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .sclk(sclk),
        .sync_n(sync_n),
        .sdin(sdin),
        .frame(frame)
    );

    ////////////////////////////////////////////////////////////////
    // Pin synchronisers
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            hw_s_q <= 2'h0;
            head_s_q <= 2'h0;
            vsh_s_q <= 2'h0;
            temp_s_q <= 2'h0;
            clear_level_select_s_q <= 2'h0;
            rset_s_q <= 2'h0;
            rng_s1_q <= 4'h0;
            rng_s2_q <= 4'h0;
        end else begin
            hw_s_q <= {hw_s_q[0], hardware_mode_pin};
            head_s_q <= {head_s_q[0], headroom_low};
            vsh_s_q <= {vsh_s_q[0], voltage_short};
            temp_s_q <= {temp_s_q[0], over_temp};
            clear_level_select_s_q <= {clear_level_select_s_q[0], clear_level_select};
            rset_s_q <= {rset_s_q[0], rset_pin};
            rng_s1_q <= range_code_pin;
            rng_s2_q <= rng_s1_q;
        end
    end

    ////////////////////////////////////////////////////////////////
    // strap caught once after reset release
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            strap_cnt_q <= 2'h0;
            hw_mode_q <= 1'b0;
        end else if (strap_cnt_q != OFC_STRAP_CYCLES) begin
            strap_cnt_q <= strap_cnt_q + 2'h1;
            hw_mode_q <= hw_s_q[1];
        end
    end

    ////////////////////////////////////////////////////////////////
    // APB slave: one setup, one access cycle, never waits
    assign setup = psel && !penable;
    assign access = psel && penable;
    assign mapped = (paddr == OFC_CFG_OFS) || (paddr == OFC_STATUS_OFS) || (paddr == OFC_MODE_OFS);
    assign pready = access;
    assign pslverr = access && !mapped;
    assign status_rd = access && !pwrite && (paddr == OFC_STATUS_OFS);

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            prdata <= 32'h00000000;
        end else if (setup && !pwrite) begin
            unique case (paddr)
                OFC_CFG_OFS: prdata <= {16'h0000, cfg_q};
                OFC_STATUS_OFS: prdata <= {28'h0000000, status_q};
                OFC_MODE_OFS: prdata <= {23'h000000, clear_target, clear_active, clear_level_select_eff,
                    cfg.overrange, cfg.bipolar, cfg.current_mode, cfg.rset_internal, hw_mode_q};
                default: prdata <= 32'h00000000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////
    // serial writes only to the addressed device, write direction
    assign frame_write = frame.frame_ok && !frame.data[OFC_RW_BIT]
        && (frame.data[OFC_ADDR_LSB +: 3] == device_addr);

    // programmed value kept through a clear
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            cfg_q <= OFC_CFG_RESET;
        end else if (frame_write) begin
            cfg_q <= frame.data[OFC_RESET_BIT] ? OFC_CFG_RESET : frame.data;
        end else if (access && pwrite && paddr == OFC_CFG_OFS) begin
            cfg_q <= pwdata[15:0];
        end
    end

    ////////////////////////////////////////////////////////////////
    // Status flags: live faults plus sticky packet error
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            status_q <= 4'h0;
        end else begin
            status_q[OFC_ST_VOLTAGE_OUTPUT_PIN] <= vsh_s_q[1];
            status_q[OFC_ST_CURRENT_LOOP_OUTPUT] <= head_s_q[1];
            status_q[OFC_ST_TEMP] <= temp_s_q[1];
            if (frame.pec_fail) begin
                status_q[OFC_ST_PEC] <= 1'b1;
            end else if (status_rd) begin
                status_q[OFC_ST_PEC] <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // open-drain alerts, levels always low
    assign fault_alert_n_o = 1'b0;
    assign loop_open_alert_n_o = 1'b0;
    assign voltage_short_alert_n_o = 1'b0;
    assign temp_alert_n_o = 1'b0;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            fault_alert_n_oe <= 1'b0;
            loop_open_alert_n_oe <= 1'b0;
            voltage_short_alert_n_oe <= 1'b0;
            temp_alert_n_oe <= 1'b0;
        end else begin
            fault_alert_n_oe <= !hw_mode_q && (|status_q);
            loop_open_alert_n_oe <= hw_mode_q && status_q[OFC_ST_CURRENT_LOOP_OUTPUT];
            voltage_short_alert_n_oe <= hw_mode_q && status_q[OFC_ST_VOLTAGE_OUTPUT_PIN];
            temp_alert_n_oe <= hw_mode_q && status_q[OFC_ST_TEMP];
        end
    end

    ////////////////////////////////////////////////////////////////
    // range and resistor from register or pins by mode
    always_comb begin
        if (hw_mode_q) begin
            cfg_d = ofc_decode(rng_s2_q, rset_s_q[1], 1'b1);
        end else begin
            cfg_d = ofc_decode(cfg_q[OFC_RANGE_LSB +: 4], cfg_q[OFC_RSET_BIT], cfg_q[OFC_OUTEN_BIT]);
        end
    end

    // overrange flag comes with the decoded code
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            cfg <= '0;
        end else begin
            cfg <= cfg_d;
        end
    end

    ////////////////////////////////////////////////////////////////
    // select is pin OR register bit, register bit outside hardware mode only
    assign clear_level_select_eff = clear_level_select_s_q[1] || (!hw_mode_q && cfg_q[OFC_CLEAR_LEVEL_SELECT_BIT]);

    // clear pin acts with no clock; software bit joins it outside hardware mode
    assign clear_active = clear_pin || (!hw_mode_q && cfg_q[OFC_SWCLR_BIT]);

    // clear value by select and range kind
    always_comb begin
        if (!clear_level_select_eff) begin
            if (cfg.current_mode) begin
                clear_target = OFC_CLR_LOW_END;
            end else if (cfg.bipolar) begin
                clear_target = OFC_CLR_NEG_FULL;
            end else begin
                clear_target = OFC_CLR_ZERO_V;
            end
        end else begin
            if (!cfg.current_mode && cfg.bipolar) begin
                clear_target = OFC_CLR_ZERO_V;
            end else begin
                clear_target = OFC_CLR_MID;
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // shared alert follows any fault outside hardware mode
    alert_shared_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        !hw_mode_q && (|status_q) |=> fault_alert_n_oe)
        else $error("Shared alert not driven on fault");

    // no shared alert in hardware mode
    alert_hw_quiet_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        hw_mode_q && $past(hw_mode_q) |-> !fault_alert_n_oe)
        else $error("Shared alert driven in hardware mode");

    loop_alert_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        hw_mode_q && $rose(status_q[OFC_ST_CURRENT_LOOP_OUTPUT]) |=> loop_open_alert_n_oe)
        else $error("Current alert missing");

    // packet error reaches status and, outside hardware mode, the shared alert
    pec_alert_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        frame.pec_fail && !hw_mode_q |=> status_q[OFC_ST_PEC] ##1 fault_alert_n_oe)
        else $error("Packet error not flagged");

    pec_discard_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        frame.pec_fail && !(access && pwrite) |=> $stable(cfg_q))
        else $error("Failed frame was written");

    pec_read_clear_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        status_rd && !frame.pec_fail |=> !status_q[OFC_ST_PEC])
        else $error("Packet error survived status read");

    frame_store_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        frame_write && !frame.data[OFC_RESET_BIT] |=> cfg_q == $past(frame.data))
        else $error("Good frame not stored");

    clear_level_select_or_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        !hw_mode_q && cfg_q[OFC_CLEAR_LEVEL_SELECT_BIT] |-> clear_level_select_eff)
        else $error("Clear select OR broken");

    // current range clears to low end when select is low
    clear_low_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        clear_pin && !clear_level_select_eff && cfg.current_mode |-> clear_active && clear_target == OFC_CLR_LOW_END)
        else $error("Wrong current clear value");

    // current overrange only on three ranges
    cur_over_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        cfg.current_mode && cfg.overrange |-> !cfg.bipolar)
        else $error("Overrange on a bipolar current range");

endmodule // ofc_top

// *** tb/ofc_ctrl_model.sv ***
// Serial controller model sending plain or checked frames
`timescale 1ns/100ps
module ofc_ctrl_model (
    output logic sclk, // Link clock, idle high
    output logic sync_n, // Frame sync
    output logic sdin // Serial data
);
    initial begin
        sclk = 1'b1;
        sync_n = 1'b1;
        sdin = 1'b0;
    end
    function automatic logic [7:0] crc(input logic [15:0] d);
        logic [7:0] c;
        c = 8'h00;
        for (int i = 15; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
        return c;
    endfunction
    task automatic send(input logic [15:0] w, input bit chk, input bit bad);
        logic [23:0] f;
        f = {w, crc(w) ^ {7'h00, bad}};
        #13 sync_n = 1'b0;
        for (int i = 23; i >= (chk ? 0 : 8); i--) begin
            sdin = f[i];
            #200 sclk = 1'b0;
            #200 sclk = 1'b1;
        end
        #100 sync_n = 1'b1;
        // Released line shows junk, not the last bit
        sdin = ~sdin;
        #500;
    endtask
endmodule // ofc_ctrl_model

// *** tb/ofc_top_tb.sv ***
// Testbench for the fault, clear and packet check logic
`timescale 1ns/100ps
module ofc_top_tb import ofc_pkg::*;;
    logic sys_clk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0, hw = 0, rset_pin = 0, clear_pin = 0, sel = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, r;
    logic [3:0] range_code_pin = 4'h0;
    logic [2:0] flt = 3'h0;
    logic pready, pslverr, sclk, sync_n, sdin, e, fa_o, fa_oe, lo_oe, vs_oe, tp_oe, clear_active;
    logic lo_o, vs_o, tp_o;
    ofc_cfg_s cfg;
    ofc_clr_e clear_target;
    int comparisons = 0, n_mismatch = 0;
    // Rows: range, select, checked, cfg, clear value
    localparam logic [16:0] ROWS [11] = '{
        {4'h1, 2'b00, 9'h023, 2'd0}, {4'h3, 2'b01, 9'h06B, 2'd1}, {4'h6, 2'b01, 9'h0CF, 2'd1},
        {4'h8, 2'b00, 9'h113, 2'd3}, {4'hC, 2'b01, 9'h19B, 2'd3}, {4'hF, 2'b00, 9'h1F7, 2'd3},
        {4'h0, 2'b11, 9'h003, 2'd2}, {4'h2, 2'b10, 9'h04B, 2'd0}, {4'hB, 2'b11, 9'h17B, 2'd2},
        {4'hD, 2'b01, 9'h1B7, 2'd3}, {4'h4, 2'b00, 9'h087, 2'd0}};
    ofc_top ofc_top_inst (.sys_clk(sys_clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .sclk(sclk),
        .sync_n(sync_n), .sdin(sdin), .device_addr(3'h0), .hardware_mode_pin(hw), .range_code_pin(range_code_pin),
        .rset_pin(rset_pin), .clear_pin(clear_pin), .clear_level_select(sel), .headroom_low(flt[1]),
        .voltage_short(flt[0]), .over_temp(flt[2]), .fault_alert_n_o(fa_o), .fault_alert_n_oe(fa_oe),
        .loop_open_alert_n_o(lo_o), .loop_open_alert_n_oe(lo_oe), .voltage_short_alert_n_o(vs_o),
        .voltage_short_alert_n_oe(vs_oe), .temp_alert_n_o(tp_o), .temp_alert_n_oe(tp_oe), .cfg(cfg),
        .clear_active(clear_active), .clear_target(clear_target));
    ofc_ctrl_model ofc_ctrl_model_inst (.sclk(sclk), .sync_n(sync_n), .sdin(sdin));
    initial begin
        forever #25 sys_clk = ~sys_clk;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string nm);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int k = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do begin
            @(posedge sys_clk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        chk(32'(pready), 32'h1, "pready");
        wt(1);
    endtask
    task automatic tx(input logic [3:0] rg, input logic cs, input logic sc, input bit c, input bit bad);
        ofc_ctrl_model_inst.send({5'h00, rg, cs, 2'b11, sc, 3'b000}, c, bad);
        wt(12);
    endtask
    task automatic rst(input logic m);
        hw <= m;
        reset_n <= 1'b0;
        repeat (3) @(posedge sys_clk);
        reset_n <= 1'b1;
        wt(6);
    endtask
    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        #2000000;
        n_mismatch++;
        complete_run();
    end
    initial begin
        rst(1'b0);
        foreach (ROWS[i]) begin
            tx(ROWS[i][16:13], ROWS[i][12], 1'b0, ROWS[i][11], 1'b0);
            chk(32'(cfg), 32'(ROWS[i][10:2]), "cfg");
            chk(32'(clear_target), 32'(ROWS[i][1:0]), "clear value");
            apb(1'b0, OFC_CFG_OFS, 32'h0);
            chk(r, {16'h0, 5'h00, ROWS[i][16:12], 2'b11, 4'h0}, "cfg word");
            apb(1'b0, OFC_STATUS_OFS, 32'h0);
            chk(r, 32'h0, "status");
        end
        tx(4'h0, 1'b0, 1'b0, 1'b0, 1'b0);
        sel <= 1'b1;
        wt(6);
        chk(32'(clear_target), 32'(OFC_CLR_MID), "pin select");
        sel <= 1'b0;
        clear_pin <= 1'b1;
        #1 chk(32'(clear_active), 32'h1, "clear pin");
        tx(4'h1, 1'b0, 1'b0, 1'b1, 1'b0);
        clear_pin <= 1'b0;
        wt(4);
        chk(32'(clear_active), 32'h0, "clear release");
        chk(32'(cfg), 32'h023, "cfg after clear");
        tx(4'h1, 1'b0, 1'b1, 1'b0, 1'b0);
        chk(32'(clear_active), 32'h1, "soft clear");
        tx(4'h1, 1'b0, 1'b0, 1'b1, 1'b1);
        chk(32'(clear_active), 32'h1, "bad frame kept");
        wt(4);
        chk(32'(fa_oe), 32'h1, "pec alert");
        chk(32'(fa_o), 32'h0, "alert level");
        apb(1'b0, OFC_STATUS_OFS, 32'h0);
        chk(r, 32'h8, "pec flag");
        wt(4);
        chk(32'(fa_oe), 32'h0, "alert release");
        apb(1'b0, OFC_STATUS_OFS, 32'h0);
        chk(r, 32'h0, "pec cleared");
        apb(1'b1, 8'h0C, 32'h0);
        chk({r[31:1], e}, 32'h1, "unmapped");
        for (int i = 0; i < 3; i++) begin
            flt <= 3'(1 << i);
            wt(8);
            chk(32'(fa_oe), 32'h1, "shared alert");
            chk(32'({tp_oe, lo_oe, vs_oe}), 32'h0, "hw alerts");
            apb(1'b0, OFC_STATUS_OFS, 32'h0);
            chk(r, 32'(1 << i), "fault status");
        end
        flt <= 3'h0;
        range_code_pin <= 4'h9;
        rset_pin <= 1'b1;
        rst(1'b1);
        chk(32'(cfg), 32'h133, "hw cfg");
        apb(1'b0, OFC_MODE_OFS, 32'h0);
        chk(32'(r[0]), 32'h1, "hw mode");
        for (int i = 0; i < 3; i++) begin
            flt <= 3'(1 << i);
            wt(8);
            chk(32'({tp_oe, lo_oe, vs_oe}), 32'(1 << i), "hw alert");
            chk(32'(fa_oe), 32'h0, "shared off");
            chk(32'({tp_o, lo_o, vs_o}), 32'h0, "hw alert level");
        end
        complete_run();
    end
endmodule // ofc_top_tb
